/* verilog/hsof_operand_file.sv */
`timescale 1ns/1ps
// What this block does
// - Pop bit picks register or stack access
// - Plain read keeps top and pointer
// - Plain write pushes new top
// - Only top entries reach the ALU
// - Same stack twice: pop bits ORed
// - Single-input ALU: B in, A out
// - Two-input ALU: A, B in, A out
// - Single branch tests A against zero
// - Double branch tests A against B
// - Memory read to A, B/PC address
// - Memory write from A, B/PC address
// - Register set: offset address, A data
// - Jump to B; call pushes return PC
// - Interrupt pushes current PC on stack 7
// - Only slot A is written, except the interrupt push to stack 7
// - Eight stacks, 4-bit operand fields
// - Stack depth is a build parameter
// - Entries and ALU data 32 bits
// - One-byte opcode, stack ops two bytes
// - Immediates 0-3 bytes, length 1-5
// - Literals 1/2/4 bytes via memory read
// - Byte addresses on 32-bit ports
module hsof_operand_file #(
  parameter int THREADS = hsof_pkg::THREADS,
  parameter int DEPTH = hsof_pkg::STACK_DEPTH,
  parameter int TW = (THREADS > 1) ? $clog2(THREADS) : 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic iss_valid,
  input wire logic [TW-1:0] iss_thread,
  input wire logic [3:0] iss_class,
  input wire logic [1:0] iss_mode,
  input wire logic [2:0] iss_cond,
  input wire logic [hsof_pkg::FIELD_W-1:0] iss_field_a,
  input wire logic [hsof_pkg::FIELD_W-1:0] iss_field_b,
  input wire logic [1:0] iss_imm_len,
  input wire logic [1:0] iss_size,
  input wire logic [hsof_pkg::IMM_W-1:0] offset_literal,
  input wire logic [hsof_pkg::PC_W-1:0] iss_pc,
  input wire logic wb_valid,
  input wire logic [TW-1:0] wb_thread,
  input wire logic [hsof_pkg::IDX_W-1:0] wb_stack,
  input wire logic wb_pop,
  input wire logic [hsof_pkg::DATA_W-1:0] wb_data,
  output logic out_valid_q,
  output logic [TW-1:0] out_thread_q,
  output logic [3:0] out_class_q,
  output logic [hsof_pkg::DATA_W-1:0] alu_a_q,
  output logic [hsof_pkg::DATA_W-1:0] alu_b_q,
  output logic dest_valid_q,
  output logic [hsof_pkg::IDX_W-1:0] dest_stack_q,
  output logic dest_pop_q,
  output logic mem_rd_q,
  output logic mem_wr_q,
  output logic [hsof_pkg::DATA_W-1:0] mem_addr_q,
  output logic [3:0] mem_be_q,
  output logic [hsof_pkg::DATA_W-1:0] mem_wr_data_q,
  output logic reg_rd_q,
  output logic reg_wr_q,
  output logic [hsof_pkg::REG_ADDR_W-1:0] reg_addr_q,
  output logic [hsof_pkg::DATA_W-1:0] reg_wr_data_q,
  output logic branch_taken_q,
  output logic [hsof_pkg::PC_W-1:0] pc_next_q,
  output logic [2:0] instr_len_q
);
  localparam int DW = hsof_pkg::DATA_W;
  localparam int NS = hsof_pkg::STACKS;
  localparam int PB = hsof_pkg::FIELD_POP_BIT;

  // Byte enables for a 1, 2 or 4 byte access within one word
  function automatic logic [3:0] lane_mask(input logic [1:0] sz, input logic [1:0] ofs);
    logic [3:0] base;
    case (sz)
      hsof_pkg::SZ_BYTE: base = 4'h1;
      hsof_pkg::SZ_HALF: base = 4'h3;
      default: base = 4'hf;
    endcase
    lane_mask = 4'(base << ofs);
  endfunction

  function automatic logic cls_is(input logic [3:0] c, input hsof_pkg::hsof_class_e k);
    cls_is = (c == k);
  endfunction

  // Operand fields: one pop bit over three index bits
  wire a_pop = iss_field_a[PB];
  wire b_pop = iss_field_b[PB];
  wire [2:0] a_idx = iss_field_a[2:0];
  wire [2:0] b_idx = iss_field_b[2:0];
  wire same_idx = (a_idx == b_idx);

  wire c_alu1 = cls_is(iss_class, hsof_pkg::CLS_ALU1);
  wire c_alu2 = cls_is(iss_class, hsof_pkg::CLS_ALU2);
  wire c_br1 = cls_is(iss_class, hsof_pkg::CLS_BR1);
  wire c_br2 = cls_is(iss_class, hsof_pkg::CLS_BR2);
  wire c_mrd = cls_is(iss_class, hsof_pkg::CLS_MEM_RD);
  wire c_mwr = cls_is(iss_class, hsof_pkg::CLS_MEM_WR);
  wire c_rrd = cls_is(iss_class, hsof_pkg::CLS_REG_RD);
  wire c_rwr = cls_is(iss_class, hsof_pkg::CLS_REG_WR);
  wire c_jmp = cls_is(iss_class, hsof_pkg::CLS_JMP);
  wire c_call = cls_is(iss_class, hsof_pkg::CLS_CALL);
  wire c_lit = cls_is(iss_class, hsof_pkg::CLS_LIT);
  wire c_irq = cls_is(iss_class, hsof_pkg::CLS_IRQ);

  wire pc_mode = (iss_mode == hsof_pkg::AM_PC_IMM);
  // Which slots each class reads
  wire b_used = c_alu1 | c_alu2 | c_br2 | c_jmp | c_call | ((c_mrd | c_mwr) & ~pc_mode);
  wire a_read_only = c_br1 | c_br2 | c_mwr | c_rwr;
  // Results land in slot A only, later, through write-back
  wire a_dest = c_alu1 | c_alu2 | c_mrd | c_rrd | c_lit;

  // A pop bit on a destination is folded into its pop-and-push
  wire b_merged = b_used & same_idx & (a_dest | c_call | a_read_only);
  wire comb_pop = a_pop | (b_merged & b_pop);
  wire iss_pop_b = iss_valid & b_used & b_pop & ~b_merged;
  wire iss_pop_a = iss_valid & a_read_only & comb_pop;
  wire dest_pop = a_dest & comb_pop;
  wire call_pop = c_call & comb_pop;

  // Tops of the indexed stacks for the issuing thread
  logic [DW-1:0] tops [NS];
  wire [DW-1:0] a_val = tops[a_idx];
  wire [DW-1:0] b_val = tops[b_idx];

  wire [2:0] len;
  wire [DW-1:0] imm_sext;
  wire [DW-1:0] mem_addr;
  wire taken;
  wire [hsof_pkg::PC_W-1:0] pc_next;

  hsof_addr_unit u_addr (
    .cls(iss_class),
    .mode(iss_mode),
    .cond(iss_cond),
    .imm_len(iss_imm_len),
    .offset_literal(offset_literal),
    .pc(iss_pc),
    .a_val(a_val),
    .b_val(b_val),
    .instr_len(len),
    .imm_sext(imm_sext),
    .mem_addr(mem_addr),
    .taken(taken),
    .pc_next(pc_next)
  );

  // Internal pushes: call return PC on A, interrupt PC on stack 7
  wire [DW-1:0] ret_pc = iss_pc + 32'(len);
  wire int_push = iss_valid & (c_call | c_irq);
  wire [2:0] int_stack = c_irq ? hsof_pkg::IRQ_STACK : a_idx;
  wire [DW-1:0] int_data = c_irq ? iss_pc : ret_pc;

  genvar s;
  generate
    for (s = 0; s < NS; s++) begin : g_stack
      wire hit_int = int_push && (int_stack == 3'(s));
      wire hit_wb = wb_valid && (wb_stack == 3'(s));
      // Plain reads neither pop nor push the stack
      wire pop_s = (iss_pop_b && b_idx == 3'(s)) || (iss_pop_a && a_idx == 3'(s));
      wire push_s = hit_int || hit_wb;
      wire push_pop_s = hit_int ? (c_call & call_pop) : wb_pop;
      wire [TW-1:0] push_thr = hit_int ? iss_thread : wb_thread;
      wire [DW-1:0] push_dat = hit_int ? int_data : wb_data;

      hsof_lifo #(
        .WIDTH(DW),
        .DEPTH(DEPTH),
        .THREADS(THREADS),
        .TW(TW)
      ) u_lifo (
        .clk(clk),
        .rst_n(rst_n),
        .pop_en(pop_s),
        .pop_thread(iss_thread),
        .push_en(push_s),
        .push_pop(push_pop_s),
        .push_thread(push_thr),
        .push_data(push_dat),
        .rd_thread(iss_thread),
        .rd_top(tops[s])
      );
    end
  endgenerate

  // Operand routing toward the ALU
  wire [DW-1:0] alu_a_d = c_alu1 ? b_val : a_val;
  wire [DW-1:0] alu_b_d = b_val;
  wire alu_any = c_alu1 | c_alu2;

  // Literals use the memory read port with their own size
  wire mem_rd_d = iss_valid & (c_mrd | c_lit);
  wire mem_wr_d = iss_valid & c_mwr;
  wire [1:0] acc_size = (c_mrd | c_mwr | c_lit) ? iss_size : 2'(hsof_pkg::SZ_WORD);
  wire [3:0] be_d = lane_mask(acc_size, mem_addr[1:0]);

  // Register set address is the absolute offset
  wire [hsof_pkg::REG_ADDR_W-1:0] reg_addr_d = offset_literal[hsof_pkg::REG_ADDR_W-1:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_q <= 1'b0;
      out_thread_q <= '0;
      out_class_q <= hsof_pkg::CLS_NOP;
      dest_valid_q <= 1'b0;
      dest_stack_q <= '0;
      dest_pop_q <= 1'b0;
      branch_taken_q <= 1'b0;
      pc_next_q <= hsof_pkg::DATA_RST;
      instr_len_q <= hsof_pkg::LEN_RST;
    end else begin
      out_valid_q <= iss_valid;
      out_thread_q <= iss_thread;
      out_class_q <= iss_class;
      dest_valid_q <= iss_valid & a_dest;
      dest_stack_q <= a_idx;
      dest_pop_q <= dest_pop;
      branch_taken_q <= iss_valid & taken;
      pc_next_q <= pc_next;
      instr_len_q <= len;
    end
  end

  // Operand and memory side; data held when the slot is idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alu_a_q <= hsof_pkg::DATA_RST;
      alu_b_q <= hsof_pkg::DATA_RST;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      mem_addr_q <= hsof_pkg::DATA_RST;
      mem_be_q <= hsof_pkg::BE_RST;
      mem_wr_data_q <= hsof_pkg::DATA_RST;
    end else begin
      if (iss_valid && (alu_any || c_br1 || c_br2)) begin
        alu_a_q <= alu_a_d;
        alu_b_q <= alu_b_d;
      end
      mem_rd_q <= mem_rd_d;
      mem_wr_q <= mem_wr_d;
      if (mem_rd_d || mem_wr_d) begin
        mem_addr_q <= mem_addr;
        mem_be_q <= be_d;
        mem_wr_data_q <= a_val;
      end
    end
  end

  // Register set side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_q <= 1'b0;
      reg_wr_q <= 1'b0;
      reg_addr_q <= '0;
      reg_wr_data_q <= hsof_pkg::DATA_RST;
    end else begin
      reg_rd_q <= iss_valid & c_rrd;
      reg_wr_q <= iss_valid & c_rwr;
      if (iss_valid && (c_rrd || c_rwr)) begin
        reg_addr_q <= reg_addr_d;
        reg_wr_data_q <= a_val;
      end
    end
  end

endmodule

/* verilog/hsof_pkg.sv */
package hsof_pkg;

  localparam int DATA_W = 32;
  localparam int STACKS = 8;
  localparam int IDX_W = 3;
  localparam int FIELD_W = 4;
  localparam int FIELD_POP_BIT = 3;
  localparam int OPCODE_W = 8;
  localparam int IMM_W = 24;
  localparam int PC_W = 32;
  localparam int REG_ADDR_W = 8;
  localparam int STACK_DEPTH = 32;
  localparam int THREADS = 8;
  localparam logic [2:0] IRQ_STACK = 3'h7;

  // Instruction length pieces, in bytes
  localparam logic [2:0] LEN_PLAIN = 3'h1;
  localparam logic [2:0] LEN_STACK = 3'h2;

  localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
  localparam logic [3:0] BE_RST = 4'h0;
  localparam logic [2:0] LEN_RST = 3'h1;

  typedef enum logic [3:0] {
    CLS_NOP = 4'h0,
    CLS_ALU1 = 4'h1,
    CLS_ALU2 = 4'h2,
    CLS_BR1 = 4'h3,
    CLS_BR2 = 4'h4,
    CLS_MEM_RD = 4'h5,
    CLS_MEM_WR = 4'h6,
    CLS_REG_RD = 4'h7,
    CLS_REG_WR = 4'h8,
    CLS_JMP = 4'h9,
    CLS_CALL = 4'ha,
    CLS_LIT = 4'hb,
    CLS_IRQ = 4'hc
  } hsof_class_e;

  typedef enum logic [1:0] {
    AM_B = 2'h0,
    AM_B_IMM = 2'h1,
    AM_PC_IMM = 2'h2
  } hsof_amode_e;

  typedef enum logic [2:0] {
    CND_EQ = 3'h0,
    CND_NE = 3'h1,
    CND_LTS = 3'h2,
    CND_GES = 3'h3,
    CND_GTS = 3'h4,
    CND_LES = 3'h5,
    CND_LTU = 3'h6,
    CND_GEU = 3'h7
  } hsof_cond_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } hsof_size_e;

endpackage

/* verilog/hsof_lifo.sv */
`timescale 1ns/1ps
// One indexed stack, with a separate pointer per thread
module hsof_lifo #(
  parameter int WIDTH = hsof_pkg::DATA_W,
  parameter int DEPTH = hsof_pkg::STACK_DEPTH,
  parameter int THREADS = hsof_pkg::THREADS,
  parameter int TW = (THREADS > 1) ? $clog2(THREADS) : 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pop_en,
  input wire logic [TW-1:0] pop_thread,
  input wire logic push_en,
  input wire logic push_pop,
  input wire logic [TW-1:0] push_thread,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic [TW-1:0] rd_thread,
  output logic [WIDTH-1:0] rd_top
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] PTR_RST = '0;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

  logic [WIDTH-1:0] mem [THREADS][DEPTH];
  logic [PW-1:0] ptr_q [THREADS];
  logic [PW-1:0] ptr_d [THREADS];

  // Popping an empty stack leaves it empty rather than wrapping
  function automatic logic [PW-1:0] drop(input logic [PW-1:0] p, input logic [1:0] n);
    logic [PW-1:0] nn;
    nn = PW'(n);
    drop = (p > nn) ? p - nn : PTR_RST;
  endfunction

  wire same_thread = pop_en && (pop_thread == push_thread);
  wire [1:0] push_drops = {1'b0, same_thread} + {1'b0, push_pop};
  wire [PW-1:0] push_base = drop(ptr_q[push_thread], push_drops);
  // A push into a full stack is dropped; the top is kept
  wire push_ok = push_en && (push_base < DEPTH_P);
  wire [PW-1:0] rd_ptr = ptr_q[rd_thread];
  wire [AW-1:0] rd_idx = AW'(rd_ptr - 1'b1);

  // Only the top entry is visible
  assign rd_top = (rd_ptr == PTR_RST) ? '0 : mem[rd_thread][rd_idx];

  always_comb begin
    for (int t = 0; t < THREADS; t++) begin
      ptr_d[t] = ptr_q[t];
      if (pop_en && pop_thread == TW'(t)) begin
        ptr_d[t] = drop(ptr_q[t], 2'h1);
      end
      if (push_en && push_thread == TW'(t)) begin
        ptr_d[t] = push_ok ? push_base + 1'b1 : push_base;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int t = 0; t < THREADS; t++) begin
        ptr_q[t] <= PTR_RST;
      end
    end else begin
      for (int t = 0; t < THREADS; t++) begin
        ptr_q[t] <= ptr_d[t];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push_ok) begin
      mem[push_thread][push_base[AW-1:0]] <= push_data;
    end
  end

endmodule

/* verilog/hsof_addr_unit.sv */
`timescale 1ns/1ps
// Instruction length, immediate extension, branch test, addresses
module hsof_addr_unit (
  input wire logic [3:0] cls,
  input wire logic [1:0] mode,
  input wire logic [2:0] cond,
  input wire logic [1:0] imm_len,
  input wire logic [hsof_pkg::IMM_W-1:0] offset_literal,
  input wire logic [hsof_pkg::PC_W-1:0] pc,
  input wire logic [hsof_pkg::DATA_W-1:0] a_val,
  input wire logic [hsof_pkg::DATA_W-1:0] b_val,
  output logic [2:0] instr_len,
  output logic [hsof_pkg::DATA_W-1:0] imm_sext,
  output logic [hsof_pkg::DATA_W-1:0] mem_addr,
  output logic taken,
  output logic [hsof_pkg::PC_W-1:0] pc_next
);
  // Offsets are signed, sign taken from the top byte in use
  function automatic logic [hsof_pkg::DATA_W-1:0] sext(input logic [hsof_pkg::IMM_W-1:0] v,
                                                       input logic [1:0] n);
    case (n)
      2'h1: sext = {{24{v[7]}}, v[7:0]};
      2'h2: sext = {{16{v[15]}}, v[15:0]};
      2'h3: sext = {{8{v[23]}}, v[23:0]};
      default: sext = '0;
    endcase
  endfunction

  function automatic logic test(input logic [2:0] c, input logic [31:0] x, input logic [31:0] y);
    case (c)
      hsof_pkg::CND_EQ: test = (x == y);
      hsof_pkg::CND_NE: test = (x != y);
      hsof_pkg::CND_LTS: test = ($signed(x) < $signed(y));
      hsof_pkg::CND_GES: test = ($signed(x) >= $signed(y));
      hsof_pkg::CND_GTS: test = ($signed(x) > $signed(y));
      hsof_pkg::CND_LES: test = ($signed(x) <= $signed(y));
      hsof_pkg::CND_LTU: test = (x < y);
      default: test = (x >= y);
    endcase
  endfunction

  wire no_stack = (cls == hsof_pkg::CLS_NOP) || (cls == hsof_pkg::CLS_IRQ);
  wire [2:0] base_len = no_stack ? hsof_pkg::LEN_PLAIN : hsof_pkg::LEN_STACK;
  assign instr_len = base_len + {1'b0, imm_len};
  assign imm_sext = sext(offset_literal, imm_len);

  // Single-input branches test against zero, two-input against B
  wire [31:0] cmp_b = (cls == hsof_pkg::CLS_BR1) ? 32'h0000_0000 : b_val;
  wire is_branch = (cls == hsof_pkg::CLS_BR1) || (cls == hsof_pkg::CLS_BR2);
  assign taken = is_branch && test(cond, a_val, cmp_b);

  // Byte address; B, B plus offset, or PC plus offset
  assign mem_addr = (mode == hsof_pkg::AM_B) ? b_val :
                    (mode == hsof_pkg::AM_B_IMM) ? b_val + imm_sext : pc + imm_sext;

  wire is_jump = (cls == hsof_pkg::CLS_JMP) || (cls == hsof_pkg::CLS_CALL);
  wire [31:0] pc_seq = pc + 32'(instr_len);
  // Interrupts resume at the same PC, so it is not advanced
  assign pc_next = taken ? pc + imm_sext :
                   is_jump ? b_val :
                   (cls == hsof_pkg::CLS_IRQ) ? pc : pc_seq;

endmodule

/* dv/hsof_chk.sv */
`timescale 1ns/1ps
module hsof_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic iss_valid,
  input wire logic [3:0] iss_class,
  input wire logic [3:0] iss_field_a,
  input wire logic [3:0] iss_field_b,
  input wire logic [1:0] iss_imm_len,
  input wire logic [23:0] offset_literal,
  input wire logic [31:0] iss_pc,
  input wire logic out_valid_q,
  input wire logic [3:0] out_class_q,
  input wire logic dest_valid_q,
  input wire logic [2:0] dest_stack_q,
  input wire logic dest_pop_q,
  input wire logic reg_rd_q,
  input wire logic reg_wr_q,
  input wire logic [7:0] reg_addr_q,
  input wire logic [31:0] pc_next_q,
  input wire logic [2:0] instr_len_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic dst_cls = iss_class inside {4'h1, 4'h2, 4'h5, 4'h7};
  wire logic ro_cls = iss_class inside {4'h0, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc};
  wire logic same_idx = iss_field_a[2:0] == iss_field_b[2:0];
  wire logic [2:0] len_c = ((iss_class == 4'h0 || iss_class == 4'hc) ? 3'h1 : 3'h2) + iss_imm_len;
  issue_echo_a: assert property (
    iss_valid |=> out_valid_q && out_class_q == $past(iss_class)) else $error("issue not echoed");
  idle_quiet_a: assert property (
    !iss_valid |=> !out_valid_q && !dest_valid_q) else $error("output without issue");
  dest_slot_a: assert property (
    iss_valid && dst_cls |=> dest_valid_q && dest_stack_q == $past(iss_field_a[2:0]))
    else $error("result not owed to slot A");
  no_dest_a: assert property (
    iss_valid && ro_cls |=> !dest_valid_q) else $error("result owed by read-only class");
  pop_merge_a: assert property (
    iss_valid && iss_class == 4'h2 && same_idx |=>
    dest_pop_q == $past(iss_field_a[3] | iss_field_b[3])) else $error("pop bits not merged");
  reg_addr_a: assert property (
    iss_valid && iss_class inside {4'h7, 4'h8} |=> (reg_rd_q || reg_wr_q) &&
    reg_addr_q == $past(offset_literal[7:0])) else $error("register address wrong");
  instr_len_a: assert property (
    iss_valid |=> instr_len_q == $past(len_c)) else $error("instruction length wrong");
  irq_pc_a: assert property (
    iss_valid && iss_class == 4'hc |=> pc_next_q == $past(iss_pc)) else $error("irq pc wrong");
  same_cv: cover property (iss_valid && iss_class == 4'h2 && same_idx);
  irq_cv: cover property (iss_valid && iss_class == 4'hc);
  b2b_cv: cover property (iss_valid ##1 iss_valid);
endmodule

/* dv/hsof_core_model.sv */
`timescale 1ns/1ps
// Decode/ALU side: turns owed results into write-backs, promptly or slowly
module hsof_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [2:0] out_thread_q,
  input wire logic [3:0] out_class_q,
  input wire logic [31:0] alu_a_q,
  input wire logic [31:0] alu_b_q,
  input wire logic dest_valid_q,
  input wire logic [2:0] dest_stack_q,
  input wire logic dest_pop_q,
  input wire logic [31:0] mem_addr_q,
  input wire logic [7:0] reg_addr_q,
  output logic wb_valid,
  output logic [2:0] wb_thread,
  output logic [2:0] wb_stack,
  output logic wb_pop,
  output logic [31:0] wb_data
);
  typedef struct packed {logic [2:0] t; logic [2:0] s; logic p; logic [31:0] d;} hsof_wb_s;
  hsof_wb_s q[$];
  hsof_wb_s e;
  int dly;
  wire logic [31:0] res = out_class_q == 4'h1 ? alu_a_q + 32'h0000_0001 :
    out_class_q == 4'h2 ? alu_a_q + alu_b_q :
    out_class_q == 4'h5 ? {mem_addr_q[15:0], ~mem_addr_q[15:0]} : {24'h5a_5aa5, reg_addr_q};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q.delete();
      dly = 0;
      wb_valid <= 1'b0;
      wb_data <= 32'h0000_0000;
    end else begin
      if (dest_valid_q === 1'b1) q.push_back({out_thread_q, dest_stack_q, dest_pop_q, res});
      if (wb_valid) begin
        // Released data and stack lines must not keep the last value
        wb_valid <= 1'b0;
        wb_data <= ~wb_data;
        wb_stack <= ~wb_stack;
      end else if (q.size() > 0) begin
        if (dly < (slow ? 3 : 0)) dly++;
        else begin
          dly = 0;
          e = q.pop_front();
          wb_valid <= 1'b1;
          wb_thread <= e.t;
          wb_stack <= e.s;
          wb_pop <= e.p;
          wb_data <= e.d;
        end
      end
    end
  end
endmodule

/* dv/hybrid_stack_operand_file_tb_top.sv */
`timescale 1ns/1ps
module hybrid_stack_operand_file_tb_top;
  localparam int DEPTH = 4;
  typedef struct packed {logic [220:0] e; logic [220:0] m;} hsof_note_s;
  logic clk = 0, rst_n = 0, iss_valid = 0, slow = 0, pend = 0;
  logic [2:0] iss_thread = 0, iss_cond = 0;
  logic [3:0] iss_class = 0, iss_field_a = 0, iss_field_b = 0;
  logic [1:0] iss_mode = 0, iss_imm_len = 0, iss_size = 0;
  logic [23:0] offset_literal = 0;
  logic [31:0] iss_pc = 0, rs = 32'h9629, r;
  logic out_valid_q, dest_valid_q, dest_pop_q, mem_rd_q, mem_wr_q, reg_rd_q, reg_wr_q;
  logic branch_taken_q, wb_valid, wb_pop;
  logic [2:0] out_thread_q, dest_stack_q, instr_len_q, wb_thread, wb_stack;
  logic [3:0] out_class_q, mem_be_q, c, fa, fb;
  logic [7:0] reg_addr_q;
  logic [31:0] alu_a_q, alu_b_q, mem_addr_q, mem_wr_data_q, reg_wr_data_q, pc_next_q, wb_data;
  logic [31:0] stk [8][8][DEPTH];
  int sp [8][8];
  int bad_count = 0, checks = 0;
  hsof_note_s notes[$];
  hsof_note_s cur;
  hsof_operand_file #(.THREADS(8), .DEPTH(DEPTH)) dut (.*);
  hsof_core_model pm (.*);
  always #2.5 clk = ~clk;
  task automatic fail(input string s);
    bad_count++;
    $display("[ERR] %0t %s", $time, s);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [31:0] top(input int t, s);
    return sp[t][s] > 0 ? stk[t][s][sp[t][s] - 1] : 32'h0000_0000;
  endfunction
  task automatic pp(input int t, s, input logic p, u, input logic [31:0] d);
    if (p && sp[t][s] > 0) sp[t][s]--;
    if (u && sp[t][s] < DEPTH) begin
      stk[t][s][sp[t][s]] = d;
      sp[t][s]++;
    end
  endtask
  function automatic logic cmp(input logic [2:0] cd, input logic [31:0] x, y);
    case (cd)
      3'h0: return x == y;
      3'h1: return x != y;
      3'h2: return $signed(x) < $signed(y);
      3'h3: return $signed(x) >= $signed(y);
      3'h4: return $signed(x) > $signed(y);
      3'h5: return $signed(x) <= $signed(y);
      3'h6: return x < y;
      default: return x >= y;
    endcase
  endfunction
  task automatic issue(input logic [3:0] c, fa, fb, input logic [1:0] md, il, sz,
                       input logic [2:0] cd, th, input logic [23:0] im, input logic [31:0] pc);
    logic [31:0] a, b, sx, ad, pn;
    logic [3:0] bm;
    logic [2:0] ln;
    logic sm, dv, mm, mw, rg, rw, bt, pa;
    hsof_note_s n;
    a = top(th, fa[2:0]);
    b = top(th, fb[2:0]);
    sm = fa[2:0] == fb[2:0];
    dv = c inside {4'h1, 4'h2, 4'h5, 4'h7};
    sx = il == 2'h0 ? 32'h0000_0000 : il == 2'h1 ? {{24{im[7]}}, im[7:0]} :
         il == 2'h2 ? {{16{im[15]}}, im[15:0]} : {{8{im[23]}}, im};
    ad = md == 2'h0 ? b : md == 2'h1 ? b + sx : pc + sx;
    ln = ((c == 4'h0 || c == 4'hc) ? 3'h1 : 3'h2) + {1'b0, il};
    bt = c == 4'h3 ? cmp(cd, a, 32'h0000_0000) : c == 4'h4 && cmp(cd, a, b);
    pn = bt ? pc + sx : (c == 4'h9 || c == 4'ha) ? b : c == 4'hc ? pc : pc + {29'h0, ln};
    bm = sz == 2'h0 ? 4'h1 : sz == 2'h1 ? 4'h3 : 4'hf;
    bm = bm << ad[1:0];
    mm = c == 4'h5 || c == 4'h6;
    mw = c == 4'h6;
    rg = c == 4'h7 || c == 4'h8;
    rw = c == 4'h8;
    n.e = {c, c == 4'h1 ? b : a, b, dv, fa[2:0], fa[3] | (sm & fb[3]), c == 4'h5, mw, ad, bm, a,
           c == 4'h7, rw, im[7:0], a, bt, pn, ln};
    n.m = {4'hf, {32{c inside {[4'h1:4'h4]}}}, {32{c == 4'h2 || c == 4'h4}}, 1'b1, {4{dv}}, 2'h3,
           {36{mm}}, {32{mw}}, 2'h3, {8{rg}}, {32{rw}}, {36{1'b1}}};
    pa = fa[3] && c inside {4'h3, 4'h4, 4'h6, 4'h8};
    if (dv) begin
      if (!sm) pp(th, fb[2:0], fb[3], 1'b0, 0);
      pp(th, fa[2:0], fa[3] | (sm & fb[3]), 1'b1, c == 4'h1 ? b + 32'h0000_0001 :
         c == 4'h2 ? a + b : c == 4'h5 ? {ad[15:0], ~ad[15:0]} : {24'h5a_5aa5, im[7:0]});
    end else begin
      pp(th, fa[2:0], pa, 1'b0, 0);
      pp(th, fb[2:0], fb[3] && !(sm && pa), 1'b0, 0);
      if (c == 4'ha) pp(th, fa[2:0], fa[3], 1'b1, pc + {29'h0, ln});
      if (c == 4'hc) pp(th, 7, 1'b0, 1'b1, pc);
    end
    notes.push_back(n);
    pend = dv;
    @(posedge clk);
    #1;
    iss_valid = 1;
    iss_class = c;
    iss_field_a = fa;
    iss_field_b = fb;
    iss_mode = md;
    iss_imm_len = il;
    iss_size = sz;
    iss_cond = cd;
    iss_thread = th;
    offset_literal = im;
    iss_pc = pc;
  endtask
  task automatic idle();
    int k;
    @(posedge clk);
    #1;
    iss_valid = 0;
    for (k = 0; pend && k < 12 && wb_valid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (pend && wb_valid !== 1'b1) fail("no write-back");
    @(posedge clk);
    #1;
  endtask
  always @(negedge clk) begin
    if (out_valid_q === 1'b1) begin
      if (notes.size() == 0) fail("unexpected result");
      else begin
        cur = notes.pop_front();
        checks++;
        if ((({out_class_q, alu_a_q, alu_b_q, dest_valid_q, dest_stack_q, dest_pop_q, mem_rd_q,
              mem_wr_q, mem_addr_q, mem_be_q, mem_wr_data_q, reg_rd_q, reg_wr_q, reg_addr_q,
              reg_wr_data_q, branch_taken_q, pc_next_q, instr_len_q} ^ cur.e) & cur.m) !== '0)
          fail("result mismatch");
      end
    end
  end
  initial begin
    #200000;
    fail("watchdog");
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1;
    // Overfill stack 2 of thread 0, then pop stack 2 of thread 1 past empty
    repeat (DEPTH + 2) begin
      issue(4'h5, 4'h2, 4'h1, 2'h2, 2'h3, 2'h2, 3'h0, 3'h0, 24'(xs()), xs());
      idle();
    end
    issue(4'h2, 4'ha, 4'ha, 2'h0, 2'h0, 2'h0, 3'h0, 3'h0, 24'h00_0000, 32'h0000_0100);
    idle();
    repeat (DEPTH + 2) begin
      issue(4'h1, 4'h3, 4'ha, 2'h0, 2'h1, 2'h0, 3'h0, 3'h1, 24'(xs()), xs());
      idle();
    end
    issue(4'h4, 4'hb, 4'hb, 2'h0, 2'h2, 2'h0, 3'h1, 3'h1, 24'(xs()), xs());
    issue(4'h4, 4'hb, 4'hb, 2'h0, 2'h2, 2'h0, 3'h0, 3'h1, 24'(xs()), xs());
    idle();
    repeat (400) begin
      r = xs();
      c = 4'(r[3:0] % 13);
      if (c == 4'hb) c = 4'h2;
      fa = r[7:4];
      fb = r[11:8];
      if (c inside {4'h0, 4'h9, 4'hc}) fa[3] = 1'b0;
      if (c inside {4'h0, 4'h3, 4'h7, 4'h8, 4'hc}) fb[3] = 1'b0;
      // PC-relative memory access never reads B, so a B pop bit there is meaningless
      if (c inside {4'h5, 4'h6} && r[13:12] == 2'h2) fb[3] = 1'b0;
      if (c == 4'ha && fa[2:0] == fb[2:0]) fb[2:0] = fa[2:0] + 3'h1;
      slow = r[31];
      issue(c, fa, fb, 2'(r[13:12] % 3), r[15:14], 2'(r[17:16] % 3), r[20:18],
            {2'h0, r[21]}, 24'(xs()), xs());
      idle();
    end
    tally_and_finish();
  end
endmodule
bind hsof_operand_file hsof_chk chk (.*);
